// [hdl/wdcfg_top.sv]
// wdcfg_top: watchdog with program-once config word, enable modes and window check.
// assumes an AXI4-Lite master on the one 10 MHz clock; sleep and clock status come from the power unit.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module wdcfg_top #(
  parameter int CNT_W = 16,
  parameter int TIMEOUT = wdcfg_pkg::TIMEOUT_DEFAULT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [wdcfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdcfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_mode,
  input wire logic sysclk_is_low_power_rc_osc,
  input wire logic low_power_rc_osc,
  input wire logic fast_rc_osc,
  input wire logic secondary_osc,
  output logic wdt_reset,
  output logic wdt_active,
  output wdcfg_pkg::wdcfg_src_t wdt_src
);
  if (CNT_W < 4 || CNT_W > 24 || TIMEOUT < 4 || TIMEOUT >= (1 << CNT_W))
  begin : g_chk
    $error("wdcfg_top: TIMEOUT must be 4 .. 2**CNT_W-1, CNT_W 4 .. 24");
  end

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT - 1);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // count at which clearing becomes legal for a given window code
  function automatic logic [CNT_W-1:0] win_start(input logic [1:0] code);
    logic [CNT_W+2:0] t;
    t = (CNT_W+3)'(TIMEOUT);
    unique case (code)
      2'h3: return CNT_W'((t * 3) >> 2);
      2'h2: return CNT_W'((t * 5) >> 3);
      2'h1: return CNT_W'(t >> 1);
      2'h0: return CNT_W'(t >> 2);
    endcase
  endfunction

  wdcfg_pkg::wdcfg_cfg_t cfg;
  logic cfg_locked;
  logic sw_en;
  logic [CNT_W-1:0] count;
  logic timeout_flag;
  logic early_flag;
  logic presc_tick;

  // config word view: fixed ones plus the programmed fields
  wire [23:0] cfg_word = wdcfg_pkg::CFG_FIXED_ONES | 24'({cfg.clk_sel, 1'b0, cfg.mux_en, 1'b0,
                         cfg.win, cfg.win_dis, cfg.en, cfg.psa, cfg.post}) << 0;
  wire [31:0] cfg_new = merge({8'h00, cfg_word}, s_axi_wdata, s_axi_wstrb);

  // write channel: both address and data must be present
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire wr_cfg = wr_go && s_axi_awaddr == wdcfg_pkg::OFF_CONFIG;
  wire wr_ctrl = wr_go && s_axi_awaddr == wdcfg_pkg::OFF_CTRL;
  wire wr_stat = wr_go && s_axi_awaddr == wdcfg_pkg::OFF_STATUS;
  wire wr_map = wr_cfg || wr_ctrl || wr_stat;
  wire wr_ok = (wr_cfg && !cfg_locked) || wr_ctrl || wr_stat;
  wire clear_req = wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[wdcfg_pkg::CTRL_CLEAR];
  wire sw_we = wr_ctrl && s_axi_wstrb[0] && cfg.en == wdcfg_pkg::EN_SOFT;
  wire ack_timeout = wr_stat && s_axi_wstrb[0] && s_axi_wdata[wdcfg_pkg::ST_TIMEOUT];
  wire ack_early = wr_stat && s_axi_wstrb[0] && s_axi_wdata[wdcfg_pkg::ST_EARLY];

  // enable decode
  wire active = (cfg.en == wdcfg_pkg::EN_ALWAYS) ||
                (cfg.en == wdcfg_pkg::EN_SOFT && sw_en) ||
                (cfg.en == wdcfg_pkg::EN_RUN && !sleep_mode);
  wire win_open = cfg.win_dis || count >= win_start(cfg.win);
  wire early = active && clear_req && !win_open;
  wire expire = active && presc_tick && count == LAST;
  // set wins over a same-cycle write-one-to-clear
  wire next_timeout_flag = expire || (timeout_flag && !ack_timeout);
  wire next_early_flag = early || (early_flag && !ack_early);

  // read decode
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  wire rd_map = s_axi_araddr == wdcfg_pkg::OFF_CONFIG || s_axi_araddr == wdcfg_pkg::OFF_CTRL ||
                s_axi_araddr == wdcfg_pkg::OFF_STATUS || s_axi_araddr == wdcfg_pkg::OFF_COUNT;
  wire [31:0] rd_val = (s_axi_araddr == wdcfg_pkg::OFF_CONFIG) ? {8'h00, cfg_word} :
                       (s_axi_araddr == wdcfg_pkg::OFF_CTRL) ? {31'h0, sw_en} :
                       (s_axi_araddr == wdcfg_pkg::OFF_STATUS) ? {26'h0, wdt_src, early_flag, timeout_flag,
                                                                  win_open, active} :
                       (s_axi_araddr == wdcfg_pkg::OFF_COUNT) ? 32'(count) : 32'h0;

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign wdt_active = active;

  wdcfg_clkpre u_clkpre (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(active),
    .cfg(cfg),
    .sleep_mode(sleep_mode),
    .sysclk_is_low_power_rc_osc(sysclk_is_low_power_rc_osc),
    .low_power_rc_osc(low_power_rc_osc),
    .fast_rc_osc(fast_rc_osc),
    .secondary_osc(secondary_osc),
    .src(wdt_src),
    .presc_tick(presc_tick)
  );

  // config survives sys_rst in real fuses; here reset means erased
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cfg <= wdcfg_pkg::wdcfg_cfg_t'(wdcfg_pkg::CFG_ERASED[12:0]);
      cfg_locked <= 1'b0;
    end
    else if (wr_cfg && !cfg_locked)
    begin
      cfg <= {cfg_new[14:13], cfg_new[11], cfg_new[9:0]};
      cfg_locked <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sw_en <= 1'b0;
    else if (sw_we)
      sw_en <= s_axi_wdata[wdcfg_pkg::CTRL_SW_EN];
  end

  // counter restarts on any reset event; pcnt keeps running through a clear or early clear, so the next period can then be short
  always_ff @(posedge clock)
  begin
    if (sys_rst || !active || expire || early || clear_req)
      count <= '0;
    else if (presc_tick)
      count <= count + CNT_W'(1);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wdt_reset <= 1'b0;
      timeout_flag <= 1'b0;
      early_flag <= 1'b0;
    end
    else
    begin
      wdt_reset <= expire || early;
      timeout_flag <= next_timeout_flag;
      early_flag <= next_early_flag;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wdcfg_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_map && wr_ok) ? wdcfg_pkg::RESP_OKAY : wdcfg_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= wdcfg_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_map ? wdcfg_pkg::RESP_OKAY : wdcfg_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  low_power_rc_osc_fixed_a: assert property (cfg.mux_en && cfg.clk_sel == 2'h3 |-> wdt_src == wdcfg_pkg::SRC_LOW_POWER_RC_OSC)
    else $error("select 11 not on low_power_rc_osc");
  frc_cond_a: assert property (cfg.mux_en && cfg.clk_sel == 2'h2 |->
    wdt_src == ((!cfg.win_dis && !sysclk_is_low_power_rc_osc && !sleep_mode) ? wdcfg_pkg::SRC_FRC : wdcfg_pkg::SRC_LOW_POWER_RC_OSC))
    else $error("select 10 source wrong");
  secondary_osc_fixed_a: assert property (cfg.mux_en && cfg.clk_sel == 2'h1 |-> wdt_src == wdcfg_pkg::SRC_SECONDARY_OSC)
    else $error("select 01 not on secondary");
  fosc_half_a: assert property (cfg.mux_en && cfg.clk_sel == 2'h0 |->
    wdt_src == ((!sysclk_is_low_power_rc_osc && !sleep_mode) ? wdcfg_pkg::SRC_FOSC2 : wdcfg_pkg::SRC_LOW_POWER_RC_OSC))
    else $error("select 00 source wrong");
  mux_off_a: assert property (!cfg.mux_en |-> wdt_src == wdcfg_pkg::SRC_LOW_POWER_RC_OSC)
    else $error("mux off but not low_power_rc_osc");
  window_width_a: assert property (!cfg.win_dis && cfg.win == 2'h0 && count < CNT_W'(TIMEOUT / 4) |-> !win_open)
    else $error("75 percent window opened early");
  early_clear_a: assert property (active && clear_req && !cfg.win_dis && !win_open |=> wdt_reset && count == '0)
    else $error("early clear did not reset");
  std_clear_a: assert property (active && clear_req && cfg.win_dis && !expire |=> !wdt_reset ##1 !wdt_reset)
    else $error("standard clear caused reset");
  always_on_a: assert property (cfg.en == wdcfg_pkg::EN_ALWAYS |-> wdt_active)
    else $error("always on mode inactive");
  soft_ctrl_a: assert property (sw_we && s_axi_wdata[0] |=> wdt_active)
    else $error("software enable ignored");
  run_only_a: assert property (cfg.en == wdcfg_pkg::EN_RUN |-> wdt_active == !sleep_mode)
    else $error("run only mode wrong");
  off_mode_a: assert property (cfg.en == wdcfg_pkg::EN_OFF |-> !wdt_active ##1 !wdt_reset)
    else $error("off mode active");
  fixed_ones_a: assert property (cfg_word[23:15] == 9'h1ff && cfg_word[12] && cfg_word[10])
    else $error("unimplemented bits not one");
  once_only_a: assert property (cfg_locked |=> $stable(cfg) && cfg_locked)
    else $error("config changed after programming");
  expire_rst_a: assert property (expire |=> wdt_reset && timeout_flag && count == '0)
    else $error("expiry did not reset");
  win_quarter_a: assert property (
    !cfg.win_dis && cfg.win == 2'h3 |-> win_open == (count >= CNT_W'((3 * TIMEOUT) / 4)))
    else $error("25 percent window wrong");
  win_three_eighth_a: assert property (
    !cfg.win_dis && cfg.win == 2'h2 |-> win_open == (count >= CNT_W'((5 * TIMEOUT) / 8)))
    else $error("37.5 percent window wrong");
  win_half_a: assert property (
    !cfg.win_dis && cfg.win == 2'h1 |-> win_open == (count >= CNT_W'(TIMEOUT / 2)))
    else $error("50 percent window wrong");
  win_wide_open_a: assert property (
    !cfg.win_dis && cfg.win == 2'h0 && count >= CNT_W'(TIMEOUT / 4) |-> win_open)
    else $error("75 percent window not open");
  std_open_a: assert property (
    cfg.win_dis |-> win_open)
    else $error("standard mode window closed");
  early_flag_set_a: assert property (
    early |=> early_flag && count == '0)
    else $error("early clear flag not set");
  early_flag_hold_a: assert property (
    early_flag && !ack_early |=> early_flag)
    else $error("early clear flag lost");
  early_flag_ack_a: assert property (
    ack_early && !early |=> !early_flag)
    else $error("early clear flag not cleared");
  late_clear_a: assert property (
    active && clear_req && win_open && !expire |=> count == '0 && !wdt_reset)
    else $error("legal clear mishandled");
  sw_ignored_a: assert property (
    wr_ctrl && cfg.en != wdcfg_pkg::EN_SOFT |=> $stable(sw_en))
    else $error("software enable changed outside soft mode");
  run_sleep_a: assert property (
    cfg.en == wdcfg_pkg::EN_RUN && sleep_mode |=> count == '0 && !wdt_reset)
    else $error("run only mode counted in sleep");
  off_count_a: assert property (
    cfg.en == wdcfg_pkg::EN_OFF |=> count == '0)
    else $error("off mode counted");
  rd_fixed_ones_a: assert property (
    rd_go && s_axi_araddr == wdcfg_pkg::OFF_CONFIG |=> s_axi_rdata[23:15] == 9'h1ff && s_axi_rdata[12] && s_axi_rdata[10])
    else $error("config read lost fixed ones");
  lock_set_a: assert property (
    wr_cfg && !cfg_locked |=> cfg_locked && s_axi_bresp == wdcfg_pkg::RESP_OKAY)
    else $error("first config write not locked");
  locked_resp_a: assert property (
    wr_cfg && cfg_locked |=> s_axi_bresp == wdcfg_pkg::RESP_SLVERR && $stable(cfg))
    else $error("locked config write accepted");
  count_bound_a: assert property (
    count <= LAST)
    else $error("count beyond timeout");
  inactive_hold_a: assert property (
    !active |=> count == '0)
    else $error("inactive watchdog counted");
  tick_count_a: assert property (
    active && presc_tick && count != LAST && !clear_req |=> count == $past(count) + CNT_W'(1))
    else $error("count missed a prescaled tick");
  timeout_hold_a: assert property (
    timeout_flag && !ack_timeout |=> timeout_flag)
    else $error("timeout flag lost");
  timeout_ack_a: assert property (
    ack_timeout && !expire |=> !timeout_flag)
    else $error("timeout flag not cleared");
endmodule

// [hdl/wdcfg_pkg.sv]
// wdcfg_pkg: constants, config word layout and types for the watchdog block.
// assumes a single 10 MHz clock and an AXI4-Lite master for software access.
package wdcfg_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // config word: 24 bits, unimplemented bits fixed to one
  localparam logic [23:0] CFG_FIXED_ONES = 24'hff9400;
  localparam logic [23:0] CFG_ERASED = 24'hffffff;
  localparam int POS_CLK_SEL = 13;
  localparam int POS_MUX_EN = 11;
  localparam int POS_WIN = 8;
  localparam int POS_WIN_DIS = 7;
  localparam int POS_EN = 5;
  localparam int POS_PSA = 4;
  localparam int POS_POST = 0;
  // control and status bits
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int ST_ACTIVE = 0;
  localparam int ST_WIN_OPEN = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_EARLY = 3;
  localparam int ST_SRC = 4;
  // prescaler ratios, default timeout and enable codes
  localparam int PRESC_LONG = 128;
  localparam int PRESC_SHORT = 32;
  localparam int TIMEOUT_DEFAULT = 256;
  localparam logic [1:0] EN_ALWAYS = 2'h3;
  localparam logic [1:0] EN_SOFT = 2'h2;
  localparam logic [1:0] EN_RUN = 2'h1;
  localparam logic [1:0] EN_OFF = 2'h0;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic mux_en;
    logic [1:0] win;
    logic win_dis;
    logic [1:0] en;
    logic psa;
    logic [3:0] post;
  } wdcfg_cfg_t;

  typedef enum logic [1:0] {SRC_LOW_POWER_RC_OSC, SRC_FRC, SRC_SECONDARY_OSC, SRC_FOSC2} wdcfg_src_t;
endpackage

// [hdl/wdcfg_clkpre.sv]
// wdcfg_clkpre: watchdog clock source selection and 1:32 / 1:128 prescaler.
// assumes oscillator ticks arrive as one-cycle enables synchronous to clock.
`timescale 1ns/1ns
module wdcfg_clkpre (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic run,
  input wire wdcfg_pkg::wdcfg_cfg_t cfg,
  input wire logic sleep_mode,
  input wire logic sysclk_is_low_power_rc_osc,
  input wire logic low_power_rc_osc,
  input wire logic fast_rc_osc,
  input wire logic secondary_osc,
  output wdcfg_pkg::wdcfg_src_t src,
  output logic presc_tick
);
  logic half;
  logic [6:0] pcnt;
  wire awake_fast = !sysclk_is_low_power_rc_osc && !sleep_mode;
  wire src_tick;
  wire [6:0] last = cfg.psa ? 7'(wdcfg_pkg::PRESC_LONG - 1) : 7'(wdcfg_pkg::PRESC_SHORT - 1);

  always_comb
  begin
    src = wdcfg_pkg::SRC_LOW_POWER_RC_OSC;
    if (cfg.mux_en)
    begin
      unique case (cfg.clk_sel)
        2'h3: src = wdcfg_pkg::SRC_LOW_POWER_RC_OSC;
        2'h2: src = (!cfg.win_dis && awake_fast) ? wdcfg_pkg::SRC_FRC : wdcfg_pkg::SRC_LOW_POWER_RC_OSC;
        2'h1: src = wdcfg_pkg::SRC_SECONDARY_OSC;
        2'h0: src = awake_fast ? wdcfg_pkg::SRC_FOSC2 : wdcfg_pkg::SRC_LOW_POWER_RC_OSC;
      endcase
    end
  end

  assign src_tick = (src == wdcfg_pkg::SRC_LOW_POWER_RC_OSC) ? low_power_rc_osc :
                    (src == wdcfg_pkg::SRC_FRC) ? fast_rc_osc :
                    (src == wdcfg_pkg::SRC_SECONDARY_OSC) ? secondary_osc : half;
  assign presc_tick = run && src_tick && (pcnt == last);

  // free half-rate enable keeps fosc/2 a true divider of the one clock
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      half <= 1'b0;
    else
      half <= !half;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !run)
      pcnt <= 7'h00;
    else if (src_tick)
      pcnt <= (pcnt == last) ? 7'h00 : pcnt + 7'h01;
  end

  presc_ratio_a: assert property (@(posedge clock) disable iff (sys_rst)
    presc_tick |-> pcnt == (cfg.psa ? 7'h7f : 7'h1f))
    else $error("prescaler tick at wrong count");
endmodule

// [sim/tb.sv]
// tb: self-checking bench for wdcfg_top over AXI4-Lite, with sleep, clock status and oscillator ticks.
// assumes the package and design files compile first; TIMEOUT shrunk to 8 to keep the run short.
`timescale 1ns/1ns
module tb;
  localparam int TMO = 8;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, tk = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, rst_q = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, wdt_reset, wdt_active;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sleep_mode = 1'h0, sysclk_is_low_power_rc_osc = 1'h0, low_power_rc_osc_tk = 1'h0, frc_tk = 1'h0, secondary_osc_tk = 1'h0;
  wdcfg_pkg::wdcfg_src_t wdt_src;
  int failures = 0, checks = 0, pulses = 0;
  always #50 clock = ~clock;
  wdcfg_top #(.TIMEOUT(TMO)) uut (.clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_mode(sleep_mode), .sysclk_is_low_power_rc_osc(sysclk_is_low_power_rc_osc), .low_power_rc_osc(low_power_rc_osc_tk),
    .fast_rc_osc(frc_tk), .secondary_osc(secondary_osc_tk), .wdt_reset(wdt_reset), .wdt_active(wdt_active),
    .wdt_src(wdt_src));
  // oscillator ticks: low_power_rc_osc every fourth cycle, fast_rc_osc and secondary_osc every other cycle
  always @(posedge clock)
  begin
    tk <= tk + 4'h1;
    low_power_rc_osc_tk <= (tk[1:0] == 2'h0);
    frc_tk <= ~frc_tk;
    secondary_osc_tk <= tk[0];
    rst_q <= wdt_reset;
    if (wdt_reset === 1'h1)
      pulses <= pulses + 1;
    if (wdt_reset === 1'h1 && rst_q === 1'h1)
      check("reset_pulse_width", 32'h2, 32'h1);
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang(input bit out);
    if (out)
    begin
      failures++;
      $display("ERROR wait expected answer seen timeout");
      finish_test;
    end
  endtask
  function automatic logic sig(input int k);
    return (k == 0) ? awready : (k == 1) ? bvalid : (k == 2) ? arready : rvalid;
  endfunction
  // waits for the edge at which the chosen handshake signal is high
  task automatic await(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (sig(k) !== 1'h1 && n < 5000);
    hang(n >= 5000);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    await(0);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    await(1);
    r = bresp;
    bready <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    await(2);
    arvalid <= 1'h0;
    await(3);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clock);
  endtask
  function automatic logic [23:0] cw(input logic [1:0] c, input logic m, input logic [1:0] w,
                                     input logic wd, input logic [1:0] e, input logic p);
    return {9'h1ff, c, 1'h1, m, 1'h1, w, wd, e, p, 4'hf};
  endfunction
  // config is program-once, so every case starts from a fresh erase
  task automatic prog(input logic [23:0] w);
    logic [1:0] r;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    wr(wdcfg_pkg::OFF_CONFIG, {8'h00, w}, r);
    check("config_resp", {30'h0, r}, 32'h0);
  endtask
  task automatic s_basic;
    logic [31:0] d;
    logic [1:0] r;
    rd(wdcfg_pkg::OFF_CONFIG, d, r);
    check("config_erased", d, 32'h00ffffff);
    check("src_erased", {30'h0, wdt_src}, 32'h0);
    wr(wdcfg_pkg::OFF_CTRL, 32'h0, r);
    check("active_erased", {31'h0, wdt_active}, 32'h1);
    wr(wdcfg_pkg::OFF_COUNT, 32'h0, r);
    check("count_wr_resp", {30'h0, r}, {30'h0, wdcfg_pkg::RESP_SLVERR});
    // standard mode: windowed needs enable field not 00
    wr(wdcfg_pkg::OFF_CONFIG, 32'h00000080, r);
    check("program_resp", {30'h0, r}, {30'h0, wdcfg_pkg::RESP_OKAY});
    wr(wdcfg_pkg::OFF_CONFIG, 32'h00ffffff, r);
    check("reprogram_resp", {30'h0, r}, {30'h0, wdcfg_pkg::RESP_SLVERR});
    rd(wdcfg_pkg::OFF_CONFIG, d, r);
    check("config_fixed_ones", d, 32'h00ff9480);
    check("config_rresp", {30'h0, r}, {30'h0, wdcfg_pkg::RESP_OKAY});
    check("active_off", {31'h0, wdt_active}, 32'h0);
  endtask
  task automatic s_src;
    logic [7:0] t [8] = '{8'h50, 8'hf0, 8'ha1, 8'ha8, 8'hb0, 8'h7e, 8'h33, 8'h34};
    for (int i = 0; i < 8; i++)
    begin
      prog(cw(t[i][7:6], t[i][5], 2'h3, t[i][4], 2'h3, 1'h1));
      sleep_mode <= t[i][3];
      sysclk_is_low_power_rc_osc <= t[i][2];
      repeat (2) @(posedge clock);
      check("clock_source", {30'h0, wdt_src}, {30'h0, t[i][1:0]});
    end
    sleep_mode <= 1'h0;
    sysclk_is_low_power_rc_osc <= 1'h0;
  endtask
  task automatic s_enable;
    logic [3:0] t [4] = '{4'h0, 4'hc, 4'h9, 4'hf};
    logic [31:0] c [4] = '{32'h1, 32'h0, 32'h0, 32'h1};
    logic [1:0] r;
    for (int e = 0; e < 4; e++)
    begin
      prog(cw(2'h3, 1'h1, 2'h3, 1'h1, e[1:0], 1'h1));
      for (int s = 0; s < 4; s++)
      begin
        sleep_mode <= (s > 1);
        wr(wdcfg_pkg::OFF_CTRL, c[s], r);
        check("active_mode", {31'h0, wdt_active}, {31'h0, t[e][3 - s]});
      end
      sleep_mode <= 1'h0;
    end
  endtask
  task automatic s_timeout(input logic p);
    int n, p0, lim;
    logic [31:0] d;
    logic [1:0] r;
    lim = TMO * (p ? 128 : 32) * 2;
    prog(cw(2'h0, 1'h1, 2'h3, 1'h1, 2'h3, p));
    p0 = pulses;
    n = 0;
    while (pulses == p0 && n < 5000)
    begin
      @(posedge clock);
      n++;
    end
    hang(n >= 5000);
    check("timeout_cycles", {31'h0, n > lim - 40 && n < lim + 40}, 32'h1);
    rd(wdcfg_pkg::OFF_STATUS, d, r);
    check("timeout_flag", {31'h0, d[wdcfg_pkg::ST_TIMEOUT]}, 32'h1);
    wr(wdcfg_pkg::OFF_STATUS, 32'h4, r);
    rd(wdcfg_pkg::OFF_STATUS, d, r);
    check("timeout_ack", {31'h0, d[wdcfg_pkg::ST_TIMEOUT]}, 32'h0);
  endtask
  task automatic s_kick;
    int p0;
    logic [1:0] r;
    prog(cw(2'h0, 1'h1, 2'h3, 1'h1, 2'h3, 1'h0));
    p0 = pulses;
    repeat (6)
    begin
      repeat (256) @(posedge clock);
      wr(wdcfg_pkg::OFF_CTRL, 32'h2, r);
    end
    check("kicked_no_reset", pulses - p0, 32'h0);
  endtask
  // one count short of the window start must trip, the start itself must not
  task automatic s_window;
    int st [4] = '{2, 4, 5, 6};
    int p0, n, tg;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++)
    begin
      prog(cw(2'h0, 1'h1, i[1:0], 1'h0, 2'h3, 1'h0));
      tg = st[i % 4] - ((i < 4) ? 1 : 0);
      n = 0;
      do
      begin
        rd(wdcfg_pkg::OFF_COUNT, d, r);
        n++;
      end
      while (d !== 32'(tg) && n < 500);
      hang(n >= 500);
      p0 = pulses;
      wr(wdcfg_pkg::OFF_CTRL, 32'h2, r);
      repeat (2) @(posedge clock);
      check("early_clear_reset", pulses - p0, {31'h0, i < 4});
      rd(wdcfg_pkg::OFF_STATUS, d, r);
      check("early_flag", {31'h0, d[wdcfg_pkg::ST_EARLY]}, {31'h0, i < 4});
      wr(wdcfg_pkg::OFF_STATUS, 32'h8, r);
      rd(wdcfg_pkg::OFF_STATUS, d, r);
      check("early_ack", {31'h0, d[wdcfg_pkg::ST_EARLY]}, 32'h0);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    s_basic;
    s_src;
    s_enable;
    s_timeout(1'h0);
    s_timeout(1'h1);
    s_kick;
    s_window;
    finish_test;
  end
endmodule
